// ### ucg_top.sv
// Serial clock generation, transmit buffer and two-entry receive FIFO
//
// Operation
// - Counter reloads at zero or low-byte write
// - One tick per counter zero
// - Transmit clock divides tick by 16/8/2
// - Async receiver steps undivided tick, 16/8 states; sync samples on edges
// - Divisor is 12 bits from two registers
// - Normal async rate is clock/16(div+1)
// - Double speed: divide by 8, async only
// - Double speed uses 8 ticks per bit, one sample each
// - Sync select and pin direction pick mode
// - Transfer clock pin used only when synchronous
// - Master drives generated clock on pin
// - Slave clock synchronised and edge detected
// - Receive FIFO two deep, one read each
// - Flags and ninth bit stored per entry
// - Shift register holds third character until start
// - One transmit buffer allows back-to-back frames
// - Frame, overrun and parity errors detected
// - Polarity zero: change rising, sample falling
`timescale 1ns/10ps
`default_nettype none
`include "ucg_params.svh"
module ucg_top #(
   parameter int FIFO_DEPTH = 2
) (
   input  wire logic        i_sys_clk,
   input  wire logic        i_resetn,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        i_rxd,
   output logic             o_txd,
   input  wire logic        i_xfer_clk_pin,
   output logic             o_xfer_clk_pin,
   output logic             o_xfer_clk_pin_oe
);
   typedef struct packed {
      logic [7:0]  ctrl;
      logic [11:0] baud;
      logic        aw_got;
      logic        w_got;
      logic [11:0] awaddr;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bvalid;
      logic        rvalid;
      logic [31:0] rdata;
      logic [8:0]  tx_buf;
      logic        tx_full;
      logic [11:0] tx_sh;
      logic [3:0]  tx_bits;
      logic [3:0]  tx_ph;
      logic        txd;
      logic [1:0]  rx_m1;
      logic        rx_s;
      ucg_pkg::ucg_rx_st_t rx_st;
      logic [3:0]  rx_ph;
      logic [3:0]  rx_idx;
      logic [8:0]  rx_sh;
      logic        rx_par;
      logic        rx_hold;
      logic        rx_ovr;
      ucg_pkg::ucg_rx_ent_t hold_ent;
      ucg_pkg::ucg_rx_ent_t [1:0] fifo;
      logic        rd_ptr;
      logic [1:0]  count;
   } ucg_top_st_t;
   ucg_top_st_t st_r, st_nxt;
   ucg_clk_if clk ();
   logic        wr_fire;
   logic        rd_fire;
   logic        pop;
   logic [3:0]  spb;
   logic        in_bit;
   logic        smp;
   logic        chg;
   logic        nbits;
   ucg_pkg::ucg_rx_ent_t done_ent;
   logic        done;
   logic        frame_ok;
   ucg_clkgen u_gen (
      .i_sys_clk   (i_sys_clk),
      .i_resetn    (i_resetn),
      .i_divisor   (st_r.baud),
      .i_div_lo_wr (wr_fire && st_r.awaddr == `UCG_OFF_BAUD_LO && st_r.wstrb[0]),
      .i_double    (st_r.ctrl[`UCG_CT_DOUBLE]),
      .i_sync      (st_r.ctrl[`UCG_CT_SYNC]),
      .i_xdir      (st_r.ctrl[`UCG_CT_XDIR]),
      .i_pol       (st_r.ctrl[`UCG_CT_POL]),
      .i_xck       (i_xfer_clk_pin),
      .o_xck       (o_xfer_clk_pin),
      .o_xck_oe    (o_xfer_clk_pin_oe),
      .clk         (clk)
   );
   assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
   assign s_axi_wready  = !st_r.w_got && !st_r.bvalid;
   assign s_axi_arready = !st_r.rvalid;
   assign s_axi_bvalid  = st_r.bvalid;
   assign s_axi_rvalid  = st_r.rvalid;
   assign s_axi_rdata   = st_r.rdata;
   assign s_axi_bresp   = 2'h0;
   assign s_axi_rresp   = 2'h0;
   assign o_txd         = st_r.txd;
   assign nbits         = st_r.ctrl[`UCG_CT_NINE];
   always_comb begin
      st_nxt   = st_r;
      done     = 1'b0;
      done_ent = '0;
      frame_ok = 1'b0;
      pop      = 1'b0;
      // Write address and data taken in either order
      if (s_axi_awvalid && s_axi_awready) begin
         st_nxt.aw_got = 1'b1;
         st_nxt.awaddr = {s_axi_awaddr[11:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
         st_nxt.w_got = 1'b1;
         st_nxt.wdata = s_axi_wdata;
         st_nxt.wstrb = s_axi_wstrb;
      end
      wr_fire = st_r.aw_got && st_r.w_got;
      if (wr_fire) begin
         st_nxt.aw_got = 1'b0;
         st_nxt.w_got  = 1'b0;
         st_nxt.bvalid = 1'b1;
         if (st_r.wstrb[0]) begin
            case (st_r.awaddr)
               `UCG_OFF_CTRL: st_nxt.ctrl = st_r.wdata[7:0];
               `UCG_OFF_BAUD_LO: st_nxt.baud[7:0] = st_r.wdata[7:0];
               `UCG_OFF_BAUD_HI: st_nxt.baud[11:8] = st_r.wdata[3:0];
               `UCG_OFF_DATA: begin
                  // Write while buffer full is dropped
                  if (!st_r.tx_full) begin
                     st_nxt.tx_buf  = {st_r.ctrl[`UCG_CT_TXB8], st_r.wdata[7:0]};
                     st_nxt.tx_full = 1'b1;
                  end
               end
               default: ;
            endcase
         end
      end
      if (st_r.bvalid && s_axi_bready) begin
         st_nxt.bvalid = 1'b0;
      end
      rd_fire = s_axi_arvalid && s_axi_arready;
      if (rd_fire) begin
         st_nxt.rvalid = 1'b1;
         case ({s_axi_araddr[11:2], 2'h0})
            `UCG_OFF_DATA: begin
               st_nxt.rdata = {24'h0, st_r.fifo[st_r.rd_ptr].data[7:0]};
               pop          = (st_r.count != 2'h0);
            end
            `UCG_OFF_STATUS: begin
               st_nxt.rdata = '0;
               st_nxt.rdata[`UCG_ST_RX_VALID] = (st_r.count != 2'h0);
               st_nxt.rdata[`UCG_ST_FE]       = st_r.fifo[st_r.rd_ptr].fe;
               st_nxt.rdata[`UCG_ST_OVR]      = st_r.fifo[st_r.rd_ptr].ovr;
               st_nxt.rdata[`UCG_ST_PE]       = st_r.fifo[st_r.rd_ptr].pe;
               st_nxt.rdata[`UCG_ST_NINTH]    = st_r.fifo[st_r.rd_ptr].data[8];
               st_nxt.rdata[`UCG_ST_TX_EMPTY] = !st_r.tx_full;
            end
            `UCG_OFF_CTRL:    st_nxt.rdata = {24'h0, st_r.ctrl};
            `UCG_OFF_BAUD_LO: st_nxt.rdata = {24'h0, st_r.baud[7:0]};
            `UCG_OFF_BAUD_HI: st_nxt.rdata = {28'h0, st_r.baud[11:8]};
            default:          st_nxt.rdata = '0;
         endcase
      end
      if (st_r.rvalid && s_axi_rready) begin
         st_nxt.rvalid = 1'b0;
      end
      // Transmitter: async uses divided enable, sync uses change edges
      chg = (clk.mode == ucg_pkg::UCG_SYNC_MST || clk.mode == ucg_pkg::UCG_SYNC_SLV) ? clk.chg_edge : clk.tx_en;
      if (chg) begin
         if (st_r.tx_bits != 4'h0) begin
            st_nxt.txd     = st_r.tx_sh[0];
            st_nxt.tx_sh   = {1'b1, st_r.tx_sh[11:1]};
            st_nxt.tx_bits = st_r.tx_bits - 4'h1;
         end else if (st_r.tx_full) begin
            // Reload straight after the stop bit, no idle gap
            st_nxt.txd     = 1'b0;
            st_nxt.tx_sh   = {2'b11, (st_r.ctrl[`UCG_CT_PAR_ODD] ^ ^st_r.tx_buf[7:0] ^ (nbits & st_r.tx_buf[8])),
                              nbits ? st_r.tx_buf : {1'b1, st_r.tx_buf[7:0]}};
            st_nxt.tx_bits = 4'd9 + {3'h0, nbits} + {3'h0, st_r.ctrl[`UCG_CT_PAR_EN]};
            if (!st_r.ctrl[`UCG_CT_PAR_EN] && !nbits) begin
               st_nxt.tx_sh[8] = 1'b1;
            end else if (!nbits) begin
               st_nxt.tx_sh[8] = st_r.ctrl[`UCG_CT_PAR_ODD] ^ ^st_r.tx_buf[7:0];
            end
            // Stop bit follows the last data or parity bit
            if (!nbits || !st_r.ctrl[`UCG_CT_PAR_EN]) begin
               st_nxt.tx_sh[9] = 1'b1;
            end
            st_nxt.tx_full = 1'b0;
         end else begin
            st_nxt.txd = 1'b1;
         end
      end
      // Receiver: async oversampled at the baud tick, sync on sample edges
      st_nxt.rx_m1 = {st_r.rx_m1[0], i_rxd};
      st_nxt.rx_s  = st_r.rx_m1[1];
      spb    = (clk.mode == ucg_pkg::UCG_ASYNC_DBL) ? 4'd7 : 4'd15;
      in_bit = st_r.rx_s;
      if (clk.mode == ucg_pkg::UCG_SYNC_MST || clk.mode == ucg_pkg::UCG_SYNC_SLV) begin
         smp = clk.smp_edge;
      end else begin
         smp = 1'b0;
         if (clk.rx_tick) begin
            if (st_r.rx_st == ucg_pkg::UCG_RX_IDLE && in_bit) begin
               st_nxt.rx_ph = 4'h0;
            end else if (st_r.rx_ph == spb) begin
               st_nxt.rx_ph = 4'h0;
            end else begin
               st_nxt.rx_ph = st_r.rx_ph + 4'h1;
            end
            smp = (st_r.rx_ph == (spb >> 1));
         end
      end
      if (smp) begin
         case (st_r.rx_st)
            ucg_pkg::UCG_RX_IDLE: begin
               if (!in_bit) begin
                  st_nxt.rx_st  = ucg_pkg::UCG_RX_DATA;
                  st_nxt.rx_idx = 4'h0;
                  st_nxt.rx_par = st_r.ctrl[`UCG_CT_PAR_ODD];
                  st_nxt.rx_hold = 1'b0;
                  st_nxt.rx_ovr = st_r.rx_hold;
               end
            end
            ucg_pkg::UCG_RX_DATA: begin
               st_nxt.rx_sh  = {in_bit, st_r.rx_sh[8:1]};
               st_nxt.rx_par = st_r.rx_par ^ in_bit;
               st_nxt.rx_idx = st_r.rx_idx + 4'h1;
               if (st_r.rx_idx == (nbits ? 4'd8 : 4'd7)) begin
                  st_nxt.rx_st = st_r.ctrl[`UCG_CT_PAR_EN] ? ucg_pkg::UCG_RX_PAR : ucg_pkg::UCG_RX_STOP;
               end
            end
            ucg_pkg::UCG_RX_PAR: begin
               st_nxt.rx_par = st_r.rx_par ^ in_bit;
               st_nxt.rx_st  = ucg_pkg::UCG_RX_STOP;
            end
            ucg_pkg::UCG_RX_STOP: begin
               frame_ok        = 1'b1;
               done_ent.data   = nbits ? st_r.rx_sh : {1'b0, st_r.rx_sh[8:1]};
               done_ent.fe     = !in_bit;
               done_ent.pe     = st_r.ctrl[`UCG_CT_PAR_EN] && st_r.rx_par;
               done_ent.ovr    = st_r.rx_ovr;
               st_nxt.rx_st    = ucg_pkg::UCG_RX_IDLE;
            end
            default: st_nxt.rx_st = ucg_pkg::UCG_RX_IDLE;
         endcase
      end
      // Third level waits in the shift stage while both entries are full
      if (frame_ok) begin
         st_nxt.hold_ent = done_ent;
         st_nxt.rx_hold  = 1'b1;
      end
      if (st_r.rx_hold && (st_r.count < 2'(FIFO_DEPTH) || pop)) begin
         done          = 1'b1;
         st_nxt.rx_hold = frame_ok;
      end
      if (done) begin
         st_nxt.fifo[st_r.rd_ptr ^ st_r.count[0]] = st_r.hold_ent;
      end
      if (pop) begin
         st_nxt.rd_ptr = !st_r.rd_ptr;
      end
      st_nxt.count = st_r.count + {1'b0, done} - {1'b0, pop};
   end
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         st_r       <= '0;
         st_r.ctrl  <= `UCG_CTRL_RST;
         st_r.baud  <= `UCG_BAUD_RST;
         st_r.txd   <= 1'b1;
         st_r.rx_m1 <= 2'h3;
         st_r.rx_s  <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule
`default_nettype wire

// ### ucg_params.svh
// Offsets, field positions, reset values and timing counts of the clock/buffer core
`ifndef UCG_PARAMS_SVH
`define UCG_PARAMS_SVH
`define UCG_OFF_DATA      12'h000
`define UCG_OFF_STATUS    12'h004
`define UCG_OFF_CTRL      12'h008
`define UCG_OFF_BAUD_LO   12'h00c
`define UCG_OFF_BAUD_HI   12'h010
`define UCG_ST_RX_VALID   0
`define UCG_ST_FE         1
`define UCG_ST_OVR        2
`define UCG_ST_PE         3
`define UCG_ST_NINTH      4
`define UCG_ST_TX_EMPTY   5
`define UCG_CT_DOUBLE     0
`define UCG_CT_SYNC       1
`define UCG_CT_XDIR       2
`define UCG_CT_POL        3
`define UCG_CT_NINE       4
`define UCG_CT_PAR_EN     5
`define UCG_CT_PAR_ODD    6
`define UCG_CT_TXB8       7
`define UCG_CTRL_RST      8'h00
`define UCG_BAUD_RST      12'h000
`define UCG_DIV_NORMAL    5'd16
`define UCG_DIV_DOUBLE    5'd8
`define UCG_DIV_SYNC      5'd2
`endif

// ### ucg_pkg.sv
// Types shared by the clock/buffer core
package ucg_pkg;
   typedef enum logic [1:0] {UCG_ASYNC_NORM, UCG_ASYNC_DBL, UCG_SYNC_MST, UCG_SYNC_SLV} ucg_mode_t;
   typedef enum logic [1:0] {UCG_RX_IDLE, UCG_RX_DATA, UCG_RX_PAR, UCG_RX_STOP} ucg_rx_st_t;
   typedef struct packed {
      logic [8:0] data;
      logic       fe;
      logic       ovr;
      logic       pe;
   } ucg_rx_ent_t;
endpackage

// ### ucg_clk_if.sv
// Clock enables passed from the generator to the serial core
`timescale 1ns/10ps
`default_nettype none
interface ucg_clk_if;
   logic tx_en;
   logic rx_tick;
   logic smp_edge;
   logic chg_edge;
   ucg_pkg::ucg_mode_t mode;
   modport gen  (output tx_en, output rx_tick, output smp_edge, output chg_edge, output mode);
   modport core (input tx_en, input rx_tick, input smp_edge, input chg_edge, input mode);
endinterface
`default_nettype wire

// ### ucg_clkgen.sv
// Baud generator, mode dividers and external transfer clock sync
`timescale 1ns/10ps
`default_nettype none
`include "ucg_params.svh"
module ucg_clkgen (
   input  wire logic   i_sys_clk,
   input  wire logic   i_resetn,
   input  wire logic [11:0] i_divisor,
   input  wire logic   i_div_lo_wr,
   input  wire logic   i_double,
   input  wire logic   i_sync,
   input  wire logic   i_xdir,
   input  wire logic   i_pol,
   input  wire logic   i_xck,
   output logic        o_xck,
   output logic        o_xck_oe,
   ucg_clk_if.gen      clk
);
   typedef struct packed {
      logic [11:0] cnt;
      logic [3:0]  pre;
      logic        xo;
      logic        s1;
      logic        s2;
      logic        s3;
   } ucg_gen_st_t;
   ucg_gen_st_t st_r, st_nxt;
   logic        tick;
   logic [4:0]  div;
   logic        tx_m;
   logic        rise;
   logic        fall;
   logic        mst_rise;
   logic        mst_fall;
   always_comb begin
      st_nxt = st_r;
      tick   = (st_r.cnt == 12'h000);
      if (tick || i_div_lo_wr) begin
         st_nxt.cnt = i_divisor;
      end else begin
         st_nxt.cnt = st_r.cnt - 12'h001;
      end
      if (!i_sync) begin
         div = i_double ? `UCG_DIV_DOUBLE : `UCG_DIV_NORMAL;
      end else begin
         div = `UCG_DIV_SYNC;                                         // Double speed ignored
      end
      tx_m = 1'b0;
      if (tick) begin
         if ({1'b0, st_r.pre} == div - 5'd1) begin
            st_nxt.pre = 4'h0;
            tx_m       = 1'b1;
         end else begin
            st_nxt.pre = st_r.pre + 4'h1;
         end
      end
      // Pin toggles every tick: one pin period per bit, divide by 2
      mst_rise = tick && !st_r.xo;
      mst_fall = tick && st_r.xo;
      if (i_sync && i_xdir && tick) begin
         st_nxt.xo = !st_r.xo;
      end
      st_nxt.s1 = i_xck;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      rise = st_r.s2 && !st_r.s3;
      fall = !st_r.s2 && st_r.s3;
   end
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   always_comb begin
      if (!i_sync) begin
         clk.mode = i_double ? ucg_pkg::UCG_ASYNC_DBL : ucg_pkg::UCG_ASYNC_NORM;
      end else begin
         clk.mode = i_xdir ? ucg_pkg::UCG_SYNC_MST : ucg_pkg::UCG_SYNC_SLV;
      end
      clk.rx_tick = tick;
      clk.tx_en   = !i_sync && tx_m;
      // Polarity picks which edge samples; the other edge changes data
      if (i_sync && i_xdir) begin
         clk.smp_edge = i_pol ? mst_rise : mst_fall;
         clk.chg_edge = i_pol ? mst_fall : mst_rise;
      end else if (i_sync) begin
         clk.smp_edge = i_pol ? rise : fall;
         clk.chg_edge = i_pol ? fall : rise;
      end else begin
         clk.smp_edge = 1'b0;
         clk.chg_edge = 1'b0;
      end
   end
   assign o_xck    = st_r.xo;
   assign o_xck_oe = i_sync && i_xdir;
endmodule
`default_nettype wire

// ### ucg_checker_properties.sv
// Port-level assertions for the clock/buffer core
`timescale 1ns/10ps
`default_nettype none
`include "ucg_params.svh"
module ucg_checker #(
   parameter int FIFO_DEPTH = 2
) (
   input  wire logic        i_sys_clk,
   input  wire logic        i_resetn,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   input  wire logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic        s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic        s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        o_xfer_clk_pin,
   input  wire logic        o_xfer_clk_pin_oe
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_resetn);
   // Shadow of mode bits and divisor, applied when the write answer is taken
   logic [11:0] a_r;
   logic [7:0]  w_r;
   logic        sync_r;
   logic        xdir_r;
   logic [11:0] div_r;
   logic        xck_r;
   logic [15:0] cnt_r;
   logic [1:0]  tog_r;
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         a_r <= 12'h000;
         w_r <= 8'h00;
         sync_r <= 1'b0;
         xdir_r <= 1'b0;
         div_r <= 12'h000;
         xck_r <= 1'b0;
         cnt_r <= 16'h0000;
         tog_r <= 2'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) a_r <= s_axi_awaddr;
         if (s_axi_wvalid && s_axi_wready) w_r <= s_axi_wdata[7:0];
         xck_r <= o_xfer_clk_pin;
         cnt_r <= (o_xfer_clk_pin != xck_r) ? 16'h0000 : cnt_r + 16'h0001;
         // First interval after a change of setting is partial, so skip two
         if (s_axi_bvalid && s_axi_bready && (a_r == `UCG_OFF_CTRL || a_r == `UCG_OFF_BAUD_LO
             || a_r == `UCG_OFF_BAUD_HI)) tog_r <= 2'h0;
         else if (o_xfer_clk_pin != xck_r && tog_r != 2'h3) tog_r <= tog_r + 2'h1;
         if (s_axi_bvalid && s_axi_bready && a_r == `UCG_OFF_CTRL) begin
            sync_r <= w_r[`UCG_CT_SYNC];
            xdir_r <= w_r[`UCG_CT_XDIR];
         end
         if (s_axi_bvalid && s_axi_bready && a_r == `UCG_OFF_BAUD_LO) div_r[7:0] <= w_r;
         if (s_axi_bvalid && s_axi_bready && a_r == `UCG_OFF_BAUD_HI) div_r[11:8] <= w_r[3:0];
      end
   end
   AST_OE_ASYNC: assert property (!s_axi_bvalid && !$past(s_axi_bvalid) && !sync_r |-> !o_xfer_clk_pin_oe)
      else $error("transfer clock driven in async mode");
   AST_OE_MASTER: assert property (!s_axi_bvalid && !$past(s_axi_bvalid) && sync_r && xdir_r |-> o_xfer_clk_pin_oe)
      else $error("master does not drive transfer clock");
   AST_OE_SLAVE: assert property (!s_axi_bvalid && !$past(s_axi_bvalid) && sync_r && !xdir_r |-> !o_xfer_clk_pin_oe)
      else $error("slave drives transfer clock");
   AST_XCK_RATE: assert property (sync_r && xdir_r && tog_r >= 2'h2 && o_xfer_clk_pin != xck_r |-> cnt_r == {4'h0, div_r})
      else $error("master transfer clock half period wrong");
   AST_AR_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   AST_R_ONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answered twice");
   AST_B_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write answer late");
   AST_AW_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answer pending");
endmodule
`default_nettype wire

// ### ucg_remote.sv
// Remote serial device: frame sender and frame receiver
`timescale 1ns/10ps
`default_nettype none
module ucg_remote (
   input  wire logic i_sys_clk,
   input  wire logic i_txd,
   output logic      o_rxd
);
   initial o_rxd = 1'b1;
   // Start, eight data bits first bit lowest, stop, then one idle bit high
   task automatic send(input logic [7:0] d, input logic stp, input int bc);
      logic [9:0] f;
      f = {stp, d, 1'b0};
      for (int i = 0; i < 11; i++) begin
         o_rxd <= (i < 10) ? f[i] : 1'b1;
         repeat (bc) @(posedge i_sys_clk);
      end
   endtask
   // Start length is measured, so the first data bit must be high
   task automatic recv(output logic [7:0] d, output int len, output int wc, input int bc);
      wc = 0;
      len = 0;
      while (i_txd !== 1'b0) begin
         @(posedge i_sys_clk);
         wc++;
      end
      while (i_txd === 1'b0) begin
         @(posedge i_sys_clk);
         len++;
      end
      repeat (bc / 2 - 1) @(posedge i_sys_clk);
      for (int i = 0; i < 8; i++) begin
         d[i] = i_txd;
         repeat (bc) @(posedge i_sys_clk);
      end
   endtask
endmodule
`default_nettype wire

// ### test_ucg_top.sv
// Register-level testbench of the clock/buffer core
`timescale 1ns/10ps
`default_nettype none
`include "ucg_params.svh"
module test_ucg_top;
   logic i_sys_clk, i_resetn, i_rxd, o_txd, i_xfer_clk_pin, o_xfer_clk_pin, o_xfer_clk_pin_oe;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, v;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0]  d1, d2;
   int          fails, n_checks, len, wc;
   ucg_top uut (.i_sys_clk, .i_resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .i_rxd, .o_txd, .i_xfer_clk_pin, .o_xfer_clk_pin, .o_xfer_clk_pin_oe);
   ucg_remote rem (.i_sys_clk, .i_txd(o_txd), .o_rxd(i_rxd));
   initial begin
      i_sys_clk = 1'b0;
      forever #5 i_sys_clk = ~i_sys_clk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic aw, w;
      aw = 1'b0;
      w = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw && w)) begin
         @(posedge i_sys_clk);
         if (s_axi_awvalid && s_axi_awready) begin
            aw = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge i_sys_clk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      @(posedge i_sys_clk);
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge i_sys_clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge i_sys_clk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      s_axi_rready <= 1'b0;
      @(posedge i_sys_clk);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Whole run is a few thousand cycles
   initial begin
      repeat (20000) @(posedge i_sys_clk);
      fails++;
      results;
   end
   initial begin
      {i_resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, i_xfer_clk_pin} = '0;
      s_axi_wstrb = 4'hf;
      fails = 0;
      n_checks = 0;
      repeat (5) @(posedge i_sys_clk);
      i_resetn <= 1'b1;
      @(posedge i_sys_clk);
      rd(`UCG_OFF_CTRL, v); chk(v, 32'h00000000);
      rd(`UCG_OFF_BAUD_LO, v); chk(v, 32'h00000000);
      rd(`UCG_OFF_STATUS, v); chk(v, 32'h00000020);
      rd(12'h100, v); chk(v, 32'h00000000);
      wr(`UCG_OFF_BAUD_HI, 32'h000000ff);
      rd(`UCG_OFF_BAUD_HI, v); chk(v, 32'h0000000f);
      wr(`UCG_OFF_BAUD_LO, 32'h000000ff);
      rd(`UCG_OFF_BAUD_LO, v); chk(v, 32'h000000ff);
      wr(`UCG_OFF_BAUD_HI, 32'h00000000);
      wr(`UCG_OFF_BAUD_LO, 32'h00000001);
      $display("register test done");
      // Divisor 1: tick every 2 cycles, 32 cycles a bit
      fork
         begin
            wr(`UCG_OFF_DATA, 32'h000000a5);
            // Buffer drops a write while full, so wait for it to drain
            do rd(`UCG_OFF_STATUS, v); while (v[`UCG_ST_TX_EMPTY] !== 1'b1);
            wr(`UCG_OFF_DATA, 32'h0000003d);
         end
         begin
            rem.recv(d1, len, wc, 32);
            chk(32'(len), 32'd32);
            rem.recv(d2, len, wc, 32);
            chk({31'h0, wc < 32}, 32'h1);
         end
      join
      chk({24'h0, d1}, 32'h000000a5);
      chk({24'h0, d2}, 32'h0000003d);
      repeat (64) @(posedge i_sys_clk);
      wr(`UCG_OFF_CTRL, 32'h00000001);
      fork
         wr(`UCG_OFF_DATA, 32'h000000a5);
         rem.recv(d1, len, wc, 16);
      join
      chk(32'(len), 32'd16);
      chk({24'h0, d1}, 32'h000000a5);
      repeat (32) @(posedge i_sys_clk);
      wr(`UCG_OFF_CTRL, 32'h00000000);
      $display("transmit test done");
      // Fourth start bit drops the held third character
      rem.send(8'h11, 1'b1, 32);
      rem.send(8'h22, 1'b0, 32);
      rem.send(8'h33, 1'b1, 32);
      rem.send(8'h44, 1'b1, 32);
      repeat (100) @(posedge i_sys_clk);
      rd(`UCG_OFF_STATUS, v); chk({29'h0, v[2:0]}, 32'h1);
      rd(`UCG_OFF_DATA, v); chk({24'h0, v[7:0]}, 32'h11);
      rd(`UCG_OFF_STATUS, v); chk({29'h0, v[2:0]}, 32'h3);
      rd(`UCG_OFF_DATA, v); chk({24'h0, v[7:0]}, 32'h22);
      rd(`UCG_OFF_STATUS, v); chk({29'h0, v[2:0]}, 32'h5);
      rd(`UCG_OFF_DATA, v); chk({24'h0, v[7:0]}, 32'h44);
      rd(`UCG_OFF_STATUS, v); chk({31'h0, v[0]}, 32'h0);
      $display("receive test done");
      wr(`UCG_OFF_CTRL, 32'h00000006);
      repeat (40) @(posedge i_sys_clk);
      chk({31'h0, o_xfer_clk_pin_oe}, 32'h1);
      wr(`UCG_OFF_CTRL, 32'h00000002);
      repeat (4) @(posedge i_sys_clk);
      chk({31'h0, o_xfer_clk_pin_oe}, 32'h0);
      // Slave pin period 12 cycles; start on first rising edge, then bit 0
      wr(`UCG_OFF_DATA, 32'h000000a5);
      for (int i = 0; i < 4; i++) begin
         i_xfer_clk_pin <= !i_xfer_clk_pin;
         repeat (6) @(posedge i_sys_clk);
         chk({31'h0, o_txd}, {31'h0, i > 1});
      end
      wr(`UCG_OFF_CTRL, 32'h00000000);
      repeat (4) @(posedge i_sys_clk);
      chk({31'h0, o_xfer_clk_pin_oe}, 32'h0);
      $display("clock mode test done");
      results;
   end
endmodule
bind ucg_top ucg_checker #(.FIFO_DEPTH(FIFO_DEPTH)) chk_i (.i_sys_clk, .i_resetn, .s_axi_awaddr,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .o_xfer_clk_pin,
   .o_xfer_clk_pin_oe);
`default_nettype wire
